// ===== design/dpu_top.sv
// Dual data pointer update logic with APB access to its registers
//
// How it works
// - The two update-enable bits let data-move and code-read accesses step the pointer used.
// - With pointer zero's update bit set, each such access through it steps it afterwards.
// - Pointer zero auto-steps up when its down bit is 0 and down when it is 1.
// - With pointer zero's update bit clear, accesses through it leave it unchanged.
// - Pointer one's down bit turns the increment command on it into a decrement.
// - Pointer one's down bit also sets its auto-step direction when its update bit is 1.
// - Pointer zero's down bit turns the increment command on it into a decrement.
// - With the signature bit at 1, code reads and programming accesses go to signature space.
// - With the signature bit at 0, code reads and programming accesses go to program memory.
// - The prefix flag picks the opposite pointer, except for the indirect jump.
// - Bit 2 of the configuration register always reads as 0.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module dpu_top
	import dpu_pkg::*;
(
	// Clock and reset
	input  wire logic                SYS_CLK,
	input  wire logic                RST,
	// APB slave
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [APB_AW-1:0]   PADDR,
	input  wire logic [31:0]         PWDATA,
	output logic      [31:0]         PRDATA,
	output logic                     PREADY,
	output logic                     PSLVERR,
	// Decoder request
	input  wire dpu_req_t            REQ,
	// Memory access answer
	output dpu_access_t              ACC,
	// Pointer values
	output logic      [15:0]         PTR_ZERO,
	output logic      [15:0]         PTR_ONE
);

	// -------------------------------------------------------------------
	// Configuration state
	// -------------------------------------------------------------------
	logic [1:0] auto_update_en;
	logic [1:0] count_down;
	logic       signature_space_select;
	logic       pointer_select;
	logic [15:0] ptr [2];
	logic [15:0] stepped [2];

	// APB strobes
	logic apb_setup;
	logic apb_done;
	logic wr_cfg;
	logic wr_zero;
	logic wr_one;
	logic mapped;

	// Request decode
	logic        tgt;
	logic        auto_kind;
	logic [7:0]  cfg_read;

	// -------------------------------------------------------------------
	// APB decode
	// -------------------------------------------------------------------
	assign apb_setup = PSEL && !PENABLE && !PREADY;
	assign apb_done  = PSEL && PENABLE && PREADY;

	// Address decode
	always_comb
	begin
		mapped = 1'b1;
		if (PADDR == OFS_PTR_CONFIG)
			mapped = 1'b1;
		else if (PADDR == OFS_PTR_ZERO)
			mapped = 1'b1;
		else if (PADDR == OFS_PTR_ONE)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	assign wr_cfg  = apb_done && PWRITE && (PADDR == OFS_PTR_CONFIG);
	assign wr_zero = apb_done && PWRITE && (PADDR == OFS_PTR_ZERO);
	assign wr_one  = apb_done && PWRITE && (PADDR == OFS_PTR_ONE);

	// Configuration as read back; bits 2 and 1 are not stored
	always_comb
	begin
		cfg_read                  = 8'h00;
		cfg_read[BIT_ONE_UPDATE]  = auto_update_en[1];
		cfg_read[BIT_ZERO_UPDATE] = auto_update_en[0];
		cfg_read[BIT_ONE_DOWN]    = count_down[1];
		cfg_read[BIT_ZERO_DOWN]   = count_down[0];
		cfg_read[BIT_SIG_SELECT]  = signature_space_select;
		cfg_read[BIT_HARD_ZERO]   = 1'b0;
		cfg_read[BIT_PTR_SELECT]  = pointer_select;
	end

	// Ready one cycle after setup: every access completes with no wait state
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= RD_ZERO;
		end
		else if (apb_setup)
		begin
			PREADY  <= 1'b1;
			PSLVERR <= !mapped;
			PRDATA  <= RD_ZERO;
			if (!PWRITE && PADDR == OFS_PTR_CONFIG)
				PRDATA <= {24'h000000, cfg_read};
			else if (!PWRITE && PADDR == OFS_PTR_ZERO)
				PRDATA <= {16'h0000, ptr[0]};
			else if (!PWRITE && PADDR == OFS_PTR_ONE)
				PRDATA <= {16'h0000, ptr[1]};
		end
		else
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

	// Configuration register; only a full write changes it
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			auto_update_en         <= 2'b00;
			count_down             <= 2'b00;
			signature_space_select <= 1'b0;
			pointer_select         <= 1'b0;
		end
		else if (wr_cfg)
		begin
			auto_update_en[1]      <= PWDATA[BIT_ONE_UPDATE];
			auto_update_en[0]      <= PWDATA[BIT_ZERO_UPDATE];
			count_down[1]          <= PWDATA[BIT_ONE_DOWN];
			count_down[0]          <= PWDATA[BIT_ZERO_DOWN];
			signature_space_select <= PWDATA[BIT_SIG_SELECT];
			pointer_select         <= PWDATA[BIT_PTR_SELECT];
		end
	end

	// -------------------------------------------------------------------
	// Pointer selection
	// -------------------------------------------------------------------
	// The prefix flips the select for every pointer op but the jump
	always_comb
	begin
		if (REQ.kind == OP_JUMP)
			tgt = pointer_select;
		else
			tgt = pointer_select ^ REQ.inverse;
	end

	assign auto_kind = (REQ.kind == OP_XDATA) || (REQ.kind == OP_CODE);

	// -------------------------------------------------------------------
	// Pointer storage, one slice per pointer
	// -------------------------------------------------------------------
	// A decoder op wins over an APB write to the same pointer in one cycle,
	// so an instruction in flight never loses its own update.
	for (genvar i = 0; i < 2; i++)
	begin : g_ptr
		logic hit;

		assign hit = REQ.valid && (tgt == 1'(i));

		dpu_ptr_step u_step
		(
			.value      (ptr[i]),
			.count_down (count_down[i]),
			.stepped    (stepped[i])
		);

		always_ff @(posedge SYS_CLK)
		begin
			if (RST)
				ptr[i] <= PTR_RESET;
			else if (hit && REQ.kind == OP_LOAD)
				ptr[i] <= REQ.data;
			else if (hit && REQ.kind == OP_INC)
				ptr[i] <= stepped[i];
			else if (hit && auto_kind && auto_update_en[i])
				ptr[i] <= stepped[i];
			else if ((i == 0) ? wr_zero : wr_one)
				ptr[i] <= PWDATA[PTR_W-1:0];
			// Otherwise hold, also for accesses with update off
		end
	end

	assign PTR_ZERO = ptr[0];
	assign PTR_ONE  = ptr[1];

	// -------------------------------------------------------------------
	// Access answer to the memory path
	// -------------------------------------------------------------------
	// Address is the pointer value before its post-update
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			ACC <= '0;
		else
		begin
			ACC.valid     <= REQ.valid && (auto_kind || REQ.kind == OP_JUMP);
			ACC.addr      <= ptr[tgt];
			ACC.code_side <= REQ.kind != OP_XDATA;
			ACC.ptr_id    <= tgt;
			// Signature space only for code reads, never for jump fetches
			ACC.sig_space <= REQ.valid && REQ.kind == OP_CODE
				&& signature_space_select;
			ACC.iap_valid <= REQ.in_application_programming;
			ACC.iap_sig   <= REQ.in_application_programming && signature_space_select;
		end
	end

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	// Snapshot of the request one cycle back, read only by the checks
	logic        h_valid;
	dpu_op_t     h_kind;
	logic        h_tgt;
	logic [15:0] h_val;
	logic        h_en;
	logic        h_down;

	// Marks a configuration read in flight; a pointer read may well show bit 2 set
	logic        h_cfg_rd;

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			h_cfg_rd <= 1'b0;
		else if (apb_setup)
			h_cfg_rd <= !PWRITE && (PADDR == OFS_PTR_CONFIG);
	end

	// Request snapshot for the post-update checks
	always_ff @(posedge SYS_CLK)
	begin
		h_valid <= REQ.valid && !RST;
		h_kind  <= REQ.kind;
		h_tgt   <= tgt;
		h_val   <= ptr[tgt];
		h_en    <= auto_update_en[tgt];
		h_down  <= count_down[tgt];
	end

	auto_step_up_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(h_valid && (h_kind == OP_XDATA || h_kind == OP_CODE) && h_en && !h_down)
		|-> ptr[h_tgt] == h_val + PTR_ONE_LSB)
		else $error("auto update did not increment");

	auto_step_down_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(h_valid && (h_kind == OP_XDATA || h_kind == OP_CODE) && h_en && h_down)
		|-> ptr[h_tgt] == h_val - PTR_ONE_LSB)
		else $error("auto update did not decrement");

	no_auto_step_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(h_valid && (h_kind == OP_XDATA || h_kind == OP_CODE) && !h_en)
		|-> ptr[h_tgt] == h_val)
		else $error("pointer changed with update disabled");

	inc_direction_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(h_valid && h_kind == OP_INC)
		|-> ptr[h_tgt] == (h_down ? h_val - PTR_ONE_LSB : h_val + PTR_ONE_LSB))
		else $error("increment command went the wrong way");

	inc_wrap_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(h_valid && h_kind == OP_INC && !h_down && h_val == PTR_MAX)
		|-> ptr[h_tgt] == PTR_RESET)
		else $error("pointer did not wrap to zero");

	sig_route_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(REQ.valid && REQ.kind == OP_CODE && signature_space_select)
		|=> ACC.valid && ACC.sig_space && ACC.code_side)
		else $error("code read missed signature space");

	code_route_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(REQ.in_application_programming && !signature_space_select) |=> ACC.iap_valid && !ACC.iap_sig)
		else $error("programming access went to signature space");

	prefix_select_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(REQ.valid && auto_kind)
		|=> ACC.ptr_id == ($past(pointer_select) ^ $past(REQ.inverse)))
		else $error("prefix did not pick the opposite pointer");

	xdata_side_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(REQ.valid && REQ.kind == OP_XDATA)
		|=> ACC.valid && !ACC.code_side && !ACC.sig_space)
		else $error("data move reached the code side");

	jump_select_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(REQ.valid && REQ.kind == OP_JUMP) |=> ACC.ptr_id == $past(pointer_select))
		else $error("jump used the prefixed pointer");

	bit_two_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(PREADY && !PSLVERR && h_cfg_rd) |-> PRDATA[BIT_HARD_ZERO] == 1'b0)
		else $error("configuration bit 2 read as one");

endmodule : dpu_top

// ===== design/dpu_pkg.sv
// Shared constants and carrier types for the dual data pointer update logic
package dpu_pkg;

	// -------------------------------------------------------------------
	// Register map (byte addresses on APB)
	// -------------------------------------------------------------------
	localparam int          APB_AW          = 8;
	localparam logic [7:0]  OFS_PTR_CONFIG  = 8'h00;
	localparam logic [7:0]  OFS_PTR_ZERO    = 8'h04;
	localparam logic [7:0]  OFS_PTR_ONE     = 8'h08;

	// -------------------------------------------------------------------
	// Pointer configuration field positions
	// -------------------------------------------------------------------
	localparam int BIT_ONE_UPDATE  = 7;
	localparam int BIT_ZERO_UPDATE = 6;
	localparam int BIT_ONE_DOWN    = 5;
	localparam int BIT_ZERO_DOWN   = 4;
	localparam int BIT_SIG_SELECT  = 3;
	localparam int BIT_HARD_ZERO   = 2;
	localparam int BIT_PTR_SELECT  = 0;

	// -------------------------------------------------------------------
	// Reset values and widths
	// -------------------------------------------------------------------
	localparam int          PTR_W       = 16;
	localparam logic [15:0] PTR_RESET   = 16'h0000;
	localparam logic [15:0] PTR_ONE_LSB = 16'h0001;
	localparam logic [15:0] PTR_MAX     = 16'hFFFF;
	localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

	// Operations issued by the instruction decoder
	typedef enum logic [2:0] {
		OP_NONE  = 3'b000,
		OP_LOAD  = 3'b001,
		OP_INC   = 3'b010,
		OP_XDATA = 3'b011,
		OP_CODE  = 3'b100,
		OP_JUMP  = 3'b101
	} dpu_op_t;

	// One decoder request
	typedef struct packed {
		logic        valid;
		dpu_op_t     kind;
		logic        inverse;
		logic [15:0] data;
		logic        in_application_programming;
	} dpu_req_t;

	// One memory access answer
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic        code_side;
		logic        sig_space;
		logic        ptr_id;
		logic        iap_valid;
		logic        iap_sig;
	} dpu_access_t;

endpackage : dpu_pkg

// ===== design/dpu_ptr_step.sv
// One-step up or down counter for a 16-bit data pointer
`timescale 1ns/1ps
module dpu_ptr_step
	import dpu_pkg::*;
(
	// Pointer in
	input  wire logic [15:0] value,
	input  wire logic        count_down,
	// Stepped pointer out
	output logic      [15:0] stepped
);

	// Full 16-bit step, wraps silently at both ends
	always_comb
	begin
		if (count_down)
			stepped = value - PTR_ONE_LSB;
		else
			stepped = value + PTR_ONE_LSB;
	end

endmodule : dpu_ptr_step

// ===== tb/dpu_dec_model.sv
// Decoder-side model that issues pointer operations to the update logic
`timescale 1ns/1ps
module dpu_dec_model
	import dpu_pkg::*;
(
	// Clock
	input  wire logic SYS_CLK,
	// Request to the pointer logic
	output dpu_req_t  REQ
);
	// Idle request from time zero
	initial
	begin
		REQ = '0;
	end

	// One op per call, a single-cycle pulse as the core issues it
	task automatic issue(input dpu_op_t k, input logic inv, input logic [15:0] d,
		input logic in_application_programming);
		@(posedge SYS_CLK);
		REQ <= '{1'b1, k, inv, d, in_application_programming};
		@(posedge SYS_CLK);
		REQ <= '0;
		#1;
	endtask : issue
endmodule : dpu_dec_model

// ===== tb/dpu_top_tb_top.sv
// Self-checking bench for the dual data pointer update logic
`timescale 1ns/1ps
module dpu_top_tb_top;
	import dpu_pkg::*;
	logic        clk;
	logic        rst;
	logic        psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic        pready, pslverr, slverr;
	dpu_req_t    req;
	dpu_access_t acc;
	logic [15:0] ptr0, ptr1;
	int          err_total, checks, cycles;

	dpu_top i_dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .REQ(req), .ACC(acc),
		.PTR_ZERO(ptr0), .PTR_ONE(ptr1));
	dpu_dec_model i_model (.SYS_CLK(clk), .REQ(req));

	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// APB transfer; the wait is open-ended, only the timeout ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdata = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic test_done;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, OFS_PTR_CONFIG, 32'h0);
		cmp("cfg reset", 32'h0, rdata);
		cmp("cfg err", 32'h0, {31'h0, slverr});
		apb(1'b1, OFS_PTR_CONFIG, 32'hFFFF_FFFF);
		apb(1'b0, OFS_PTR_CONFIG, 32'h0);
		cmp("cfg bit2", 32'h0000_00F9, rdata);
		apb(1'b0, 8'h0C, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, slverr});
		cmp("unmapped data", 32'h0, rdata);
		cmp("ptr reset", 32'h0, {ptr1, ptr0});
	endtask : t_regs

	task automatic t_inc;
		apb(1'b1, OFS_PTR_CONFIG, 32'h0);
		apb(1'b1, OFS_PTR_ZERO, 32'hFFFF);
		i_model.issue(OP_INC, 1'b0, 16'h0, 1'b0);
		cmp("inc wrap", 32'h0, {16'h0, ptr0});
		apb(1'b1, OFS_PTR_CONFIG, 32'h30);
		i_model.issue(OP_INC, 1'b0, 16'h0, 1'b0);
		cmp("dec wrap", 32'hFFFF, {16'h0, ptr0});
		i_model.issue(OP_INC, 1'b1, 16'h0, 1'b0);
		cmp("inv dec one", 32'hFFFF, {16'h0, ptr1});
		i_model.issue(OP_LOAD, 1'b1, 16'h1234, 1'b0);
		cmp("inv load", 32'h1234_FFFF, {ptr1, ptr0});
	endtask : t_inc

	task automatic t_auto;
		apb(1'b1, OFS_PTR_CONFIG, 32'h40);
		apb(1'b1, OFS_PTR_ZERO, 32'h0100);
		i_model.issue(OP_XDATA, 1'b0, 16'h0, 1'b0);
		cmp("xdata acc", {15'h0, 17'h1_0100}, {15'h0, acc.valid, acc.addr});
		cmp("xdata side", 32'h0, {31'h0, acc.code_side});
		cmp("post inc", 32'h0101, {16'h0, ptr0});
		apb(1'b1, OFS_PTR_CONFIG, 32'h50);
		i_model.issue(OP_CODE, 1'b0, 16'h0, 1'b0);
		cmp("code acc", {15'h0, 17'h1_0101}, {15'h0, acc.valid, acc.addr});
		cmp("code side", 32'h1, {31'h0, acc.code_side});
		cmp("post dec", 32'h0100, {16'h0, ptr0});
		apb(1'b1, OFS_PTR_CONFIG, 32'h10);
		i_model.issue(OP_XDATA, 1'b0, 16'h0, 1'b0);
		cmp("no update", 32'h0100, {16'h0, ptr0});
		apb(1'b1, OFS_PTR_CONFIG, 32'hA1);
		i_model.issue(OP_XDATA, 1'b0, 16'h0, 1'b0);
		cmp("one id", 32'h1, {31'h0, acc.ptr_id});
		cmp("one auto", 32'h1233_0100, {ptr1, ptr0});
		apb(1'b0, OFS_PTR_ONE, 32'h0);
		cmp("ptr one read", 32'h1233, rdata);
	endtask : t_auto

	task automatic t_sig;
		apb(1'b1, OFS_PTR_CONFIG, 32'h08);
		i_model.issue(OP_CODE, 1'b0, 16'h0, 1'b0);
		cmp("sig code", 32'h1, {31'h0, acc.sig_space});
		i_model.issue(OP_NONE, 1'b0, 16'h0, 1'b1);
		cmp("sig iap", 32'h3, {30'h0, acc.iap_valid, acc.iap_sig});
		i_model.issue(OP_JUMP, 1'b1, 16'h0, 1'b0);
		cmp("jump", 32'h4, {29'h0, acc.valid, acc.sig_space, acc.ptr_id});
		apb(1'b1, OFS_PTR_CONFIG, 32'h0);
		i_model.issue(OP_CODE, 1'b0, 16'h0, 1'b1);
		cmp("prog code", 32'h2, {30'h0, acc.iap_valid, acc.sig_space});
		cmp("prog iap", 32'h0, {31'h0, acc.iap_sig});
	endtask : t_sig

	// Cut a hang short well past the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			test_done();
		end
	end

	// Main sequence
	initial
	begin
		err_total = 0;
		checks = 0;
		cycles = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_inc();
		t_auto();
		t_sig();
		test_done();
	end
endmodule : dpu_top_tb_top
